//--- pin_ctrl_pkg.sv
// Shared constants and carrier types for the digital pin input control block.
// Assumes a single 20 MHz core clock domain and pins already sampled synchronously.
package pin_ctrl_pkg;

  // ****************************************
  // Sizes and pin ranges
  // ****************************************
  localparam int PIN_COUNT     = 16;
  localparam int SEL_WIDTH     = 4;
  localparam logic [3:0] LOW_PIN_MAX  = 4'hB;  // Functions limited to pins 0..11
  localparam logic [3:0] FULL_PIN_MAX = 4'hF;  // Functions allowed on pins 0..15

  // ****************************************
  // Gain and attenuation ranges and resets
  // ****************************************
  localparam int GAIN_WIDTH  = 8;
  localparam int ATTEN_WIDTH = 10;
  localparam logic [7:0] GAIN_MIN_RESET  = 8'hC3;  // 195
  localparam logic [7:0] GAIN_MAX_RESET  = 8'hFF;  // 255
  localparam logic [7:0] GAIN_RESET      = 8'hFF;
  localparam logic [9:0] ATTEN_RESET     = 10'h000;
  localparam logic [9:0] ATTEN_MAX       = 10'h3FF;

  // ****************************************
  // Timing
  // ****************************************
  localparam real SYS_CLK_MHZ  = 184.32;
  localparam int  PULSE_SYS_CYCLES = 2;
  localparam real CORE_CLK_MHZ = 20.0;
  // Least pulse time in ns, rounded up to core cycles, at least one
  localparam real PULSE_MIN_NS = PULSE_SYS_CYCLES * 1000.0 / SYS_CLK_MHZ;
  localparam int  PULSE_MIN_CYCLES_RAW = int'($ceil(PULSE_MIN_NS * CORE_CLK_MHZ / 1000.0));
  localparam int  PULSE_MIN_CYCLES = (PULSE_MIN_CYCLES_RAW < 1) ? 1 : PULSE_MIN_CYCLES_RAW;
  localparam int  RAMP_DELAY_WIDTH = 8;
  localparam logic [7:0] RAMP_DELAY_RESET = 8'h00;

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [1:0]
  {
    RAMP_IDLE    = 2'b00,
    RAMP_UP_WAIT = 2'b01,
    RAMP_DN_WAIT = 2'b10
  } ramp_state_type;

  // Pin function assignment: selector plus enable per function
  typedef struct packed
  {
    logic                 enable;
    logic [SEL_WIDTH-1:0] pin;
  } pin_map_type;

  typedef struct packed
  {
    pin_map_type obsRxEnable;
    pin_map_type attenUp;
    pin_map_type attenDown;
    pin_map_type gainUp;
    pin_map_type gainDown;
    pin_map_type rampEnable;
    pin_map_type monitorEnable;
    pin_map_type powerSave;
    pin_map_type hopEvent;
    pin_map_type hopGain;
    pin_map_type hopFreq;
  } pin_assign_type;

endpackage

//--- pin_edge_detect.sv
// Selects one input pin, registers it and reports rising and falling edges.
// Assumes pins are synchronous to core_clk; map validity is checked by the caller.
`timescale 1ns/10ps
module pin_edge_detect
#(
  parameter int PINS = 16,
  parameter int SELW = 4
)
(
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            clkEn,
  input  wire logic [PINS-1:0] pinIn,
  input  wire logic [SELW-1:0] pinSel,
  input  wire logic            selValid,
  output logic                 level,
  output logic                 rise,
  output logic                 fall
);

  // Selected pin, gated off when the map is not valid
  wire selBit = selValid & pinIn[pinSel];
  logic lastLevel;

  // Two stage register: level, then previous level
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      level     <= 1'b0;
      lastLevel <= 1'b0;
    end
    else if (clkEn)
    begin
      level     <= selBit;
      lastLevel <= level;
    end
  end

  // One edge per transition, however long the pin stays high
  assign rise = level & ~lastLevel;
  assign fall = ~level & lastLevel;

endmodule

//--- digital_pin_input_control.sv
// Input side control of the sixteen digital pins: steps, ramp triggers, mode pins.
// Assumes pin direction config and pins synchronous to core_clk; one core clock domain.
`timescale 1ns/10ps

// How it works
// - Each pin has its own direction bit; only input pins feed controls.
// - Observation receiver enable may only sit on pins 0 to 11.
// - Each rising edge on an attenuation pin steps attenuation once.
// - Attenuation up and down may use any pin 0 to 15.
// - Every pulse counts, so repeated pulses accumulate.
// - Attenuation pins act only in attenuation pin mode.
// - Each rising edge on a gain pin steps the gain index once.
// - Gain up on pins 0 to 15, gain down on pins 0 to 11.
// - Gain index saturates at programmed minimum and maximum.
// - Gain pins act only in manual gain pin mode.
// - Ramp pin rise and fall trigger ramp up and down after a delay.
// - Monitor enable may only sit on pins 0 to 11.
// - Monitor pin rise sets monitor mode; its falling edge clears it and wakes from sleep.
// - Power saving control may only sit on pins 0 to 11.
// - Hop event on pins 0 to 11, hop gain and frequency 0 to 15.
module digital_pin_input_control
#(
  parameter int PINS  = pin_ctrl_pkg::PIN_COUNT,
  parameter int SELW  = pin_ctrl_pkg::SEL_WIDTH,
  parameter int GAINW = pin_ctrl_pkg::GAIN_WIDTH,
  parameter int ATTW  = pin_ctrl_pkg::ATTEN_WIDTH,
  parameter int DLYW  = pin_ctrl_pkg::RAMP_DELAY_WIDTH
)
(
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        clkEn,
  input  wire logic [PINS-1:0]             pinIn,
  input  wire logic [PINS-1:0]             pinIsInput,
  input  wire pin_ctrl_pkg::pin_assign_type pinAssign,
  input  wire logic                        attenPinMode,
  input  wire logic                        gainPinMode,
  input  wire logic [GAINW-1:0]            gainMin,
  input  wire logic [GAINW-1:0]            gainMax,
  input  wire logic [DLYW-1:0]             rampUpDelay,
  input  wire logic [DLYW-1:0]             rampDownDelay,
  output logic [ATTW-1:0]                  txAtten,
  output logic [GAINW-1:0]                 gainIndex,
  output logic                             obsRxEnable,
  output logic                             rampUpTrigger,
  output logic                             rampDownTrigger,
  output logic                             monitorMode,
  output logic                             wakeFromSleep,
  output logic                             powerDown,
  output logic                             hopEventPulse,
  output logic                             hopGainLevel,
  output logic                             hopFreqLevel,
  output logic                             mapError
);

  // ****************************************
  // Function map validation
  // ****************************************

  localparam int FUNCS = 11;

  // Function order: obs, attUp, attDn, gainUp, gainDn, ramp, mon, pwr, hopEv, hopGain, hopFreq
  pin_ctrl_pkg::pin_map_type maps [FUNCS];
  assign maps[0]  = pinAssign.obsRxEnable;
  assign maps[1]  = pinAssign.attenUp;
  assign maps[2]  = pinAssign.attenDown;
  assign maps[3]  = pinAssign.gainUp;
  assign maps[4]  = pinAssign.gainDown;
  assign maps[5]  = pinAssign.rampEnable;
  assign maps[6]  = pinAssign.monitorEnable;
  assign maps[7]  = pinAssign.powerSave;
  assign maps[8]  = pinAssign.hopEvent;
  assign maps[9]  = pinAssign.hopGain;
  assign maps[10] = pinAssign.hopFreq;

  // Highest pin each function may use
  wire logic [3:0] pinLimit [FUNCS];
  assign pinLimit[0]  = pin_ctrl_pkg::LOW_PIN_MAX;
  assign pinLimit[1]  = pin_ctrl_pkg::FULL_PIN_MAX;
  assign pinLimit[2]  = pin_ctrl_pkg::FULL_PIN_MAX;
  assign pinLimit[3]  = pin_ctrl_pkg::FULL_PIN_MAX;
  assign pinLimit[4]  = pin_ctrl_pkg::LOW_PIN_MAX;
  assign pinLimit[5]  = pin_ctrl_pkg::FULL_PIN_MAX;
  assign pinLimit[6]  = pin_ctrl_pkg::LOW_PIN_MAX;
  assign pinLimit[7]  = pin_ctrl_pkg::LOW_PIN_MAX;
  assign pinLimit[8]  = pin_ctrl_pkg::LOW_PIN_MAX;
  assign pinLimit[9]  = pin_ctrl_pkg::FULL_PIN_MAX;
  assign pinLimit[10] = pin_ctrl_pkg::FULL_PIN_MAX;

  // A function is live when enabled, in range and its pin is an input
  logic [FUNCS-1:0] funcValid;
  logic [FUNCS-1:0] funcBad;
  logic [FUNCS-1:0] funcLevel;
  logic [FUNCS-1:0] funcRise;
  logic [FUNCS-1:0] funcFall;
  logic             shareClash;

  genvar g;
  generate
    for (g = 0; g < FUNCS; g++)
    begin : gFunc
      wire inRange = ({1'b0, maps[g].pin} <= {1'b0, pinLimit[g]});
      assign funcValid[g] = maps[g].enable & inRange & pinIsInput[maps[g].pin];
      assign funcBad[g]   = maps[g].enable & ~funcValid[g];
      pin_edge_detect #(.PINS(PINS), .SELW(SELW)) pin_edge_detect_i
      (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .pinIn    (pinIn),
        .pinSel   (maps[g].pin),
        .selValid (funcValid[g]),
        .level    (funcLevel[g]),
        .rise     (funcRise[g]),
        .fall     (funcFall[g])
      );
    end
  endgenerate

  // Two enabled functions on one pin is a software fault, flagged only
  always_comb
  begin
    shareClash = 1'b0;
    for (int i = 0; i < FUNCS; i++)
    begin
      for (int j = i + 1; j < FUNCS; j++)
      begin
        if (maps[i].enable && maps[j].enable && (maps[i].pin == maps[j].pin))
        begin
          shareClash = 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Attenuation stepping
  // ****************************************

  wire attUpEv = attenPinMode & funcRise[1];
  wire attDnEv = attenPinMode & funcRise[2];
  wire attAtMax = (txAtten == pin_ctrl_pkg::ATTEN_MAX);
  wire attAtMin = (txAtten == pin_ctrl_pkg::ATTEN_RESET);

  // Coincident up and down cancel; limits keep the count from wrapping
  logic [ATTW-1:0] next_txAtten;
  always_comb
  begin
    next_txAtten = txAtten;
    if (attUpEv && !attDnEv && !attAtMax)
    begin
      next_txAtten = txAtten + ATTW'(1);
    end
    else if (attDnEv && !attUpEv && !attAtMin)
    begin
      next_txAtten = txAtten - ATTW'(1);
    end
  end

  // ****************************************
  // Gain index stepping
  // ****************************************

  wire gainUpEv = gainPinMode & funcRise[3];
  wire gainDnEv = gainPinMode & funcRise[4];

  // Saturating step within the programmed window
  logic [GAINW-1:0] next_gainIndex;
  always_comb
  begin
    next_gainIndex = gainIndex;
    if (gainUpEv && !gainDnEv && (gainIndex < gainMax))
    begin
      next_gainIndex = gainIndex + GAINW'(1);
    end
    else if (gainDnEv && !gainUpEv && (gainIndex > gainMin))
    begin
      next_gainIndex = gainIndex - GAINW'(1);
    end
    if (next_gainIndex > gainMax)
    begin
      next_gainIndex = gainMax;
    end
    else if (next_gainIndex < gainMin)
    begin
      next_gainIndex = gainMin;
    end
  end

  // Step registers, every qualifying edge applied
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      txAtten   <= pin_ctrl_pkg::ATTEN_RESET;
      gainIndex <= pin_ctrl_pkg::GAIN_RESET;
    end
    else if (clkEn)
    begin
      txAtten   <= next_txAtten;
      gainIndex <= next_gainIndex;
    end
  end

  // ****************************************
  // Amplifier ramp delay
  // ****************************************

  pin_ctrl_pkg::ramp_state_type rampState;
  pin_ctrl_pkg::ramp_state_type next_rampState;
  logic [DLYW-1:0] rampCount;
  logic [DLYW-1:0] next_rampCount;
  logic            next_rampUp;
  logic            next_rampDown;

  // New edge restarts the wait; delay zero fires two cycles after the edge
  always_comb
  begin
    next_rampState = rampState;
    next_rampCount = rampCount;
    next_rampUp    = 1'b0;
    next_rampDown  = 1'b0;
    if (funcRise[5])
    begin
      next_rampState = pin_ctrl_pkg::RAMP_UP_WAIT;
      next_rampCount = rampUpDelay;
    end
    else if (funcFall[5])
    begin
      next_rampState = pin_ctrl_pkg::RAMP_DN_WAIT;
      next_rampCount = rampDownDelay;
    end
    else
    begin
      case (rampState)
        pin_ctrl_pkg::RAMP_UP_WAIT:
        begin
          if (rampCount == '0)
          begin
            next_rampUp    = 1'b1;
            next_rampState = pin_ctrl_pkg::RAMP_IDLE;
          end
          else
          begin
            next_rampCount = rampCount - DLYW'(1);
          end
        end
        pin_ctrl_pkg::RAMP_DN_WAIT:
        begin
          if (rampCount == '0)
          begin
            next_rampDown  = 1'b1;
            next_rampState = pin_ctrl_pkg::RAMP_IDLE;
          end
          else
          begin
            next_rampCount = rampCount - DLYW'(1);
          end
        end
        default:
        begin
          next_rampState = pin_ctrl_pkg::RAMP_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Output registers
  // ****************************************

  logic next_monitorMode;
  assign next_monitorMode = funcRise[6] ? 1'b1 : (funcFall[6] ? 1'b0 : monitorMode);

  // State, triggers and mode outputs
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rampState       <= pin_ctrl_pkg::RAMP_IDLE;
      rampCount       <= pin_ctrl_pkg::RAMP_DELAY_RESET;
      rampUpTrigger   <= 1'b0;
      rampDownTrigger <= 1'b0;
      obsRxEnable     <= 1'b0;
      monitorMode     <= 1'b0;
      wakeFromSleep   <= 1'b0;
      powerDown       <= 1'b0;
      hopEventPulse   <= 1'b0;
      hopGainLevel    <= 1'b0;
      hopFreqLevel    <= 1'b0;
      mapError        <= 1'b0;
    end
    else if (clkEn)
    begin
      rampState       <= next_rampState;
      rampCount       <= next_rampCount;
      rampUpTrigger   <= next_rampUp;
      rampDownTrigger <= next_rampDown;
      obsRxEnable     <= funcLevel[0];
      monitorMode     <= next_monitorMode;
      wakeFromSleep   <= funcFall[6];
      powerDown       <= funcLevel[7];
      hopEventPulse   <= funcRise[8];
      hopGainLevel    <= funcLevel[9];
      hopFreqLevel    <= funcLevel[10];
      mapError        <= shareClash | (|funcBad);
    end
  end

  // ****************************************
  // Checks
  // ****************************************

  property p_gain_window;
    @(posedge core_clk) disable iff (rst)
      (clkEn && gainMin <= gainMax && $stable(gainMin) && $stable(gainMax)
       && gainIndex >= gainMin && gainIndex <= gainMax)
      |=> (gainIndex >= gainMin && gainIndex <= gainMax);
  endproperty
  a_gain_window: assert property (p_gain_window) else $error("gain index left window");

  property p_gain_mode;
    @(posedge core_clk) disable iff (rst)
      (clkEn && !gainPinMode && $stable(gainMin) && gainIndex >= gainMin && gainIndex <= gainMax)
      |=> $stable(gainIndex);
  endproperty
  a_gain_mode: assert property (p_gain_mode) else $error("gain moved outside pin mode");

  property p_atten_mode;
    @(posedge core_clk) disable iff (rst)
      (clkEn && !attenPinMode) |=> $stable(txAtten);
  endproperty
  a_atten_mode: assert property (p_atten_mode) else $error("attenuation moved outside pin mode");

  property p_atten_step;
    @(posedge core_clk) disable iff (rst)
      (clkEn && attUpEv && !attDnEv && !attAtMax) |=> (txAtten == $past(txAtten) + ATTW'(1));
  endproperty
  a_atten_step: assert property (p_atten_step) else $error("attenuation did not step up");

  property p_one_step;
    @(posedge core_clk) disable iff (rst)
      (clkEn && funcRise[1]) |=> !funcRise[1];
  endproperty
  a_one_step: assert property (p_one_step) else $error("double edge from one pulse");

  property p_ramp_zero;
    @(posedge core_clk) disable iff (rst)
      (clkEn && funcRise[5] && rampUpDelay == '0) ##1 (clkEn && !funcRise[5] && !funcFall[5])[*1]
      |=> rampUpTrigger;
  endproperty
  a_ramp_zero: assert property (p_ramp_zero) else $error("ramp up not fired");

  property p_wake;
    @(posedge core_clk) disable iff (rst)
      (clkEn && funcFall[6]) |=> (wakeFromSleep && !monitorMode);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on monitor fall");

  property p_low_range;
    @(posedge core_clk) disable iff (rst)
      (pinAssign.gainDown.pin > pin_ctrl_pkg::LOW_PIN_MAX) |-> !funcValid[4];
  endproperty
  a_low_range: assert property (p_low_range) else $error("gain down on high pin accepted");

endmodule

//--- bb_pin_driver.sv
// Baseband side model: drives the sixteen digital_io_pin control lines.
// Assumes the bench calls its tasks; every change lands just after core_clk rises.
`timescale 1ns/10ps
module bb_pin_driver
(
  input  wire logic   core_clk,
  output logic [15:0] pinLevel
);
  // ****************************************
  // Pin drive tasks
  // ****************************************
  initial pinLevel = 16'h0000;

  // Set one pin; each function has a pin of its own
  task automatic drivePin(input int idx, input logic val);
    @(posedge core_clk);
    pinLevel[idx] <= val;
  endtask

  // High for hi cycles, then low for lo cycles, both at least one
  task automatic pulse(input int idx, input int hi, input int lo);
    drivePin(idx, 1'b1);
    repeat (hi - 1) @(posedge core_clk);
    drivePin(idx, 1'b0);
    repeat (lo - 1) @(posedge core_clk);
  endtask
endmodule

//--- digital_pin_input_control_tb_top.sv
// Self-checking bench for the digital pin input control block.
// Assumes the baseband model in bb_pin_driver; notes expected results in queues.
`timescale 1ns/10ps
`define CHK(g, e) begin chkExp = 32'(e); samplesChecked++; if ((g) !== chkExp) begin failures++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, chkExp); end end
module digital_pin_input_control_tb_top;
  // ****************************************
  // Signals, model and design
  // ****************************************
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [15:0] pinIsInput = 16'hFFFF;
  logic attenPinMode = 1'b1;
  logic gainPinMode = 1'b1;
  logic [7:0] gainMin = pin_ctrl_pkg::GAIN_MIN_RESET;
  logic [7:0] gainMax = pin_ctrl_pkg::GAIN_MAX_RESET;
  logic [7:0] rampUpDelay = 8'h00;
  logic [7:0] rampDownDelay = 8'h00;
  wire  logic [15:0] pins;
  logic [9:0] txAtten, lastAtt;
  logic [7:0] gainIndex, lastGain;
  logic obsRxEnable, rampUpTrigger, rampDownTrigger, monitorMode, wakeFromSleep;
  logic powerDown, hopEventPulse, hopGainLevel, hopFreqLevel, mapError;
  logic [31:0] seed = 32'h7;
  logic [31:0] chkExp;
  int failures = 0;
  int samplesChecked = 0;
  int cyc = 0;
  logic [9:0] attQ[$];
  logic [7:0] gainQ[$];
  logic [31:0] evQ[$];
  // Base map: obsRx 0, atten 15/14, gain 13/11, ramp 10, monitor 1, save 2, hop 3..5
  localparam pin_ctrl_pkg::pin_assign_type BASE = {5'h10, 5'h1F, 5'h1E, 5'h1D, 5'h1B, 5'h1A,
                                                   5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
  pin_ctrl_pkg::pin_assign_type pinAssign = BASE;

  always #25 core_clk = ~core_clk;

  bb_pin_driver bb_pin_driver_i (.core_clk(core_clk), .pinLevel(pins));

  digital_pin_input_control digital_pin_input_control_i (
    .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .pinIn(pins), .pinIsInput(pinIsInput),
    .pinAssign(pinAssign), .attenPinMode(attenPinMode), .gainPinMode(gainPinMode),
    .gainMin(gainMin), .gainMax(gainMax), .rampUpDelay(rampUpDelay), .rampDownDelay(rampDownDelay),
    .txAtten(txAtten), .gainIndex(gainIndex), .obsRxEnable(obsRxEnable),
    .rampUpTrigger(rampUpTrigger), .rampDownTrigger(rampDownTrigger), .monitorMode(monitorMode),
    .wakeFromSleep(wakeFromSleep), .powerDown(powerDown), .hopEventPulse(hopEventPulse),
    .hopGainLevel(hopGainLevel), .hopFreqLevel(hopFreqLevel), .mapError(mapError));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Note an expected step (kind 1 atten, 2 gain, 0 none) and pulse the pin
  task automatic hit(input int pin, input int kind, input logic [9:0] exp);
    if (kind == 1) attQ.push_back(exp);
    if (kind == 2) gainQ.push_back(exp[7:0]);
    bb_pin_driver_i.pulse(pin, 1 + xs() % 3, 1 + xs() % 3);
  endtask

  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // ****************************************
  // Output watcher: takes oldest note on each result
  // ****************************************
  always @(negedge core_clk)
  begin
    if (!rst)
    begin
      if (txAtten !== lastAtt)
      begin
        `CHK(txAtten, attQ.pop_front());
        lastAtt = txAtten;
      end
      if (gainIndex !== lastGain)
      begin
        `CHK(gainIndex, gainQ.pop_front());
        lastGain = gainIndex;
      end
      if (rampUpTrigger === 1'b1) `CHK({8'h01, cyc[23:0]}, evQ.pop_front());
      if (rampDownTrigger === 1'b1) `CHK({8'h02, cyc[23:0]}, evQ.pop_front());
      if (wakeFromSleep === 1'b1) `CHK({8'h03, cyc[23:0]}, evQ.pop_front());
      if (hopEventPulse === 1'b1) `CHK({8'h04, cyc[23:0]}, evQ.pop_front());
    end
    cyc++;
    if (cyc == 4000)
    begin
      failures++;
      end_sim();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    int c, du, dd;
    pin_ctrl_pkg::pin_assign_type pa;
    lastAtt = pin_ctrl_pkg::ATTEN_RESET;
    lastGain = pin_ctrl_pkg::GAIN_RESET;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    `CHK(txAtten, pin_ctrl_pkg::ATTEN_RESET);
    `CHK(gainIndex, pin_ctrl_pkg::GAIN_RESET);
    `CHK(mapError, 1'b0);
    // Attenuation: four up, two down, then one long hold
    for (int i = 0; i < 6; i++) hit(i < 4 ? 15 : 14, 1, i < 4 ? i + 1 : 7 - i);
    attQ.push_back(10'h003);
    bb_pin_driver_i.pulse(15, 12, 2);
    // Clock enable low: a whole pulse passes unseen
    clkEn <= 1'b0;
    hit(15, 0, 0);
    settle();
    clkEn <= 1'b1;
    attenPinMode <= 1'b0;
    hit(15, 0, 0);
    settle();
    attenPinMode <= 1'b1;
    pinIsInput <= 16'h7FFF;
    hit(15, 0, 0);
    settle();
    `CHK(mapError, 1'b1);
    pinIsInput <= 16'hFFFF;
    // Gain index steps, mode gating and saturation
    hit(13, 0, 0);
    for (int i = 0; i < 3; i++) hit(11, 2, 254 - i);
    settle();
    gainPinMode <= 1'b0;
    hit(11, 0, 0);
    settle();
    gainPinMode <= 1'b1;
    gainMin <= 8'hFA;
    for (int i = 0; i < 4; i++) hit(11, i < 2 ? 2 : 0, 251 - i);
    hit(13, 2, 10'h0FB);
    // Level functions follow their pins
    for (int i = 0; i < 3; i++)
    begin
      for (int v = 1; v >= 0; v--)
      begin
        bb_pin_driver_i.drivePin(i * 2, v[0]);
        settle();
        `CHK({hopGainLevel, powerDown, obsRxEnable} >> i & 3'h1, 3'(v));
      end
    end
    // Monitor pin: rise enters, fall leaves and wakes
    bb_pin_driver_i.drivePin(1, 1'b1);
    settle();
    `CHK(monitorMode, 1'b1);
    bb_pin_driver_i.drivePin(1, 1'b0);
    c = cyc;
    evQ.push_back({8'h03, 24'(c + 2)});
    settle();
    `CHK(monitorMode, 1'b0);
    // Hop event gives one pulse; hop frequency follows its pin
    bb_pin_driver_i.drivePin(3, 1'b1);
    c = cyc;
    evQ.push_back({8'h04, 24'(c + 2)});
    bb_pin_driver_i.drivePin(5, 1'b1);
    settle();
    `CHK(hopFreqLevel, 1'b1);
    bb_pin_driver_i.drivePin(3, 1'b0);
    bb_pin_driver_i.drivePin(5, 1'b0);
    settle();
    `CHK(hopFreqLevel, 1'b0);
    // Ramp: a one-cycle hold discards the pending rise, then full pulses, last with zero up delay
    for (int k = 0; k < 3; k++)
    begin
      du = (k == 2) ? 0 : 2 + xs() % 6;
      dd = xs() % 6;
      rampUpDelay <= du[7:0];
      rampDownDelay <= dd[7:0];
      bb_pin_driver_i.drivePin(10, 1'b1);
      c = cyc;
      if (k > 0) evQ.push_back({8'h01, 24'(c + 3 + du)});
      repeat (k * 12) @(posedge core_clk);
      bb_pin_driver_i.drivePin(10, 1'b0);
      c = cyc;
      evQ.push_back({8'h02, 24'(c + 3 + dd)});
      repeat (20) @(posedge core_clk);
    end
    // Each function moved to pin 12: only the low-range ones are flagged
    for (int f = 0; f < 11; f++)
    begin
      pa = BASE;
      pa[(10 - f) * 5 +: 4] = 4'hC;
      pinAssign <= pa;
      settle();
      `CHK(mapError, (f == 0 || f == 4 || (f >= 6 && f <= 8)));
    end
    pa = BASE;
    pa[45 +: 4] = 4'h0;
    pinAssign <= pa;
    settle();
    `CHK(mapError, 1'b1);
    pinAssign <= BASE;
    settle();
    `CHK(attQ.size() + gainQ.size() + evQ.size(), 0);
    end_sim();
  end
endmodule
